// [hdl/amrc_pkg.sv]
package amrc_pkg;

  // Register addresses
  localparam logic [15:0] ADDR_LIVE_INT   = 16'h000c;
  localparam logic [15:0] ADDR_LIVE_IN    = 16'h000d;
  localparam logic [15:0] ADDR_LIVE_LH    = 16'h000e;
  localparam logic [15:0] ADDR_LIVE_CAL   = 16'h000f;
  localparam logic [15:0] ADDR_STICKY_INT = 16'h0011;
  localparam logic [15:0] ADDR_STICKY_IN  = 16'h0012;
  localparam logic [15:0] ADDR_STICKY_LH  = 16'h0013;
  localparam logic [15:0] ADDR_STICKY_CAL = 16'h0014;
  localparam logic [15:0] ADDR_MSK_INT    = 16'h0017;
  localparam logic [15:0] ADDR_MSK_IN     = 16'h0018;
  localparam logic [15:0] ADDR_MSK_LH     = 16'h0019;
  localparam logic [15:0] ADDR_MSK_CAL    = 16'h001a;
  localparam logic [15:0] ADDR_SOFT_RST   = 16'h001c;
  localparam logic [15:0] ADDR_FREQ_STEP  = 16'h001d;
  localparam logic [15:0] ADDR_POWER      = 16'h001e;
  localparam logic [15:0] ADDR_WIRE_CFG   = 16'h002b;
  localparam logic [15:0] ADDR_LOSS_EN    = 16'h002c;
  localparam logic [15:0] ADDR_VAL_TIME   = 16'h002d;
  localparam logic [15:0] ADDR_TRIG0_LO   = 16'h002e;
  localparam logic [15:0] ADDR_TRIG0_HI   = 16'h002f;
  localparam logic [15:0] ADDR_TRIG1_LO   = 16'h0030;
  localparam logic [15:0] ADDR_TRIG1_HI   = 16'h0031;
  localparam logic [15:0] ADDR_TRIG2_LO   = 16'h0032;
  localparam logic [15:0] ADDR_TRIG2_HI   = 16'h0033;

  // Bit positions
  localparam int BIT_CAL_PROGRESS = 0;
  localparam int BIT_REF_PIN_LOSS = 1;
  localparam int BIT_BUS_TIMEOUT  = 5;
  localparam int BIT_UNLOCK       = 1;
  localparam int BIT_HOLDOVER     = 5;
  localparam int BIT_LOOP_CAL     = 5;
  localparam int BIT_SOFT_ALL     = 0;
  localparam int BIT_SOFT_OUTER   = 2;
  localparam int BIT_STEP_UP      = 0;
  localparam int BIT_STEP_DOWN    = 1;
  localparam int BIT_LOW_POWER    = 0;
  localparam int BIT_HARD_RST     = 1;
  localparam int BIT_DIV_SYNC     = 2;
  localparam int BIT_THREE_LINE   = 3;
  localparam int BIT_AUTO_REFRESH = 5;
  localparam int BIT_REF_LOSS_OFF = 4;
  localparam int NUM_INPUTS       = 4;
  localparam int NUM_TRIG         = 3;

  // Implemented bits of each flag/mask byte
  localparam logic [7:0] INT_BITS = 8'h23;
  localparam logic [7:0] LH_BITS  = 8'h22;
  localparam logic [7:0] CAL_BITS = 8'h20;
  localparam logic [7:0] MSK_INT_BITS = 8'he3;

  // Reset values
  localparam logic [7:0] MSK_INT_RST = 8'hc0;
  localparam logic [7:0] MSK_IN_RST  = 8'h00;
  localparam logic [7:0] MSK_LH_RST  = 8'h00;
  localparam logic [7:0] MSK_CAL_RST = 8'h00;

  // Validation times and their cycle counts
  localparam int CLK_KHZ     = 200000;
  localparam int VAL_MS_0    = 2;
  localparam int VAL_MS_1    = 100;
  localparam int VAL_MS_2    = 200;
  localparam int VAL_MS_3    = 1000;
  localparam int VAL_CYC_0   = VAL_MS_0 * CLK_KHZ;
  localparam int VAL_CYC_1   = VAL_MS_1 * CLK_KHZ;
  localparam int VAL_CYC_2   = VAL_MS_2 * CLK_KHZ;
  localparam int VAL_CYC_3   = VAL_MS_3 * CLK_KHZ;
  localparam int VAL_CNT_W   = 28;

endpackage

// [hdl/amrc_alarm_ctrl.sv]
`timescale 1ns/1ps

// Behaviour
// - Mask bit 0 blocks calibration-progress flag interrupt
// - Mask bit 1 blocks reference-pin loss interrupt
// - Mask bit 5 blocks bus-timeout flag interrupt
// - Reserved mask bits 6,7 reset to one
// - Mask one blocks alarm, zero lets through
// - Input mask: loss bits 3:0, frequency 7:4
// - Unlock mask bit 1, holdover mask bit 5
// - Calibration mask bit 5 blocks busy flag
// - Soft reset: bit0 whole device, bit2 outer
// - Strobe bits clear themselves after acting
// - Rising edge bit0 steps frequency up
// - Rising edge bit1 steps frequency down
// - Power bit0 holds low power mode
// - Hard reset spares serial port logic
// - Self-clearing bit2 aligns all output dividers
// - Loss enable bits 3:0 per input
// - Bit4 one disables reference-pin loss detection
// - Two-bit validation time per input field
// - Loss alarm held until clean validation time
// - Sixteen-bit trigger levels, low byte first
// - Sticky flags set on status, cleared writing zero
module amrc_alarm_ctrl #(
  parameter int VAL_CYC0 = amrc_pkg::VAL_CYC_0,
  parameter int VAL_CYC1 = amrc_pkg::VAL_CYC_1,
  parameter int VAL_CYC2 = amrc_pkg::VAL_CYC_2,
  parameter int VAL_CYC3 = amrc_pkg::VAL_CYC_3
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Register port from serial configuration decoder
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Live status from analog monitors
  input  wire logic        cal_progress,
  input  wire logic        ref_pin_loss,
  input  wire logic        bus_timeout,
  input  wire logic [3:0]  signal_missing,
  input  wire logic [3:0]  freq_out_of_range,
  input  wire logic        loop_unlocked,
  input  wire logic        holdover,
  input  wire logic        loop_cal_busy,
  // Interrupt
  output logic             irq_out,
  // Strobes and controls
  output logic             soft_reset_all,
  output logic             outer_loop_init,
  output logic             freq_step_up,
  output logic             freq_step_down,
  output logic             divider_sync,
  output logic             hard_reset,
  output logic             low_power_request,
  output logic             three_line_select,
  output logic             auto_divider_refresh,
  // Loss detector setup and result
  output logic      [3:0]  input_loss_detect_on,
  output logic             ref_pin_loss_detect_off,
  output logic      [15:0] input_loss_trigger_level0,
  output logic      [15:0] input_loss_trigger_level1,
  output logic      [15:0] input_loss_trigger_level2,
  output logic      [3:0]  input_loss_alarm
);

  localparam int STAT_W = 14;
  localparam int CW     = amrc_pkg::VAL_CNT_W;
  localparam int NI     = amrc_pkg::NUM_INPUTS;

  // Positions in the sampled status vector
  localparam int POS_CAL  = 0;
  localparam int POS_REF  = 1;
  localparam int POS_TMO  = 2;
  localparam int POS_LOSS = 3;
  localparam int POS_FREQ = POS_LOSS + NI;
  localparam int POS_UNLK = POS_FREQ + NI;
  localparam int POS_HOLD = POS_UNLK + 1;
  localparam int POS_LCAL = POS_HOLD + 1;

  typedef struct packed {
    logic [STAT_W-1:0]                sync1;
    logic [STAT_W-1:0]                sync2;
    logic [STAT_W-1:0]                sync3;
    logic [STAT_W-1:0]                filt;
    logic [7:0]                       msk_int;
    logic [7:0]                       msk_in;
    logic [7:0]                       msk_lh;
    logic [7:0]                       msk_cal;
    logic [7:0]                       sticky_int;
    logic [7:0]                       sticky_in;
    logic [7:0]                       sticky_lh;
    logic [7:0]                       sticky_cal;
    logic                             low_power;
    logic                             hard_rst;
    logic                             three_line;
    logic                             auto_refresh;
    logic [3:0]                       loss_en;
    logic                             ref_loss_off;
    logic [7:0]                       val_time;
    logic [amrc_pkg::NUM_TRIG-1:0][15:0] trig;
    logic [3:0]                       alarm;
    logic [NI-1:0][CW-1:0]            cnt;
    logic                             soft_all;
    logic                             soft_outer;
    logic                             step_up;
    logic                             step_down;
    logic                             div_sync;
    logic                             irq;
    logic [7:0]                       rdata;
  } amrc_state_t;

  amrc_state_t r;
  amrc_state_t next_r;

  function automatic amrc_state_t reset_state();
    amrc_state_t s;
    s         = '0;
    s.msk_int = amrc_pkg::MSK_INT_RST;
    s.msk_in  = amrc_pkg::MSK_IN_RST;
    s.msk_lh  = amrc_pkg::MSK_LH_RST;
    s.msk_cal = amrc_pkg::MSK_CAL_RST;
    return s;
  endfunction

  // Host writes 0 to clear; a new event in the same cycle still wins
  function automatic logic [7:0] sticky_next(input logic [7:0] flag, input logic [7:0] live,
                                             input logic wr_hit, input logic [7:0] wdata,
                                             input logic [7:0] bits);
    logic [7:0] clr;
    clr = wr_hit ? ~wdata : 8'h00;
    return ((flag & ~clr) | live) & bits;
  endfunction

  function automatic logic [CW-1:0] val_limit(input logic [1:0] sel);
    logic [CW-1:0] v;
    unique case (sel)
      2'h0: v = CW'(VAL_CYC0 - 1);
      2'h1: v = CW'(VAL_CYC1 - 1);
      2'h2: v = CW'(VAL_CYC2 - 1);
      2'h3: v = CW'(VAL_CYC3 - 1);
    endcase
    return v;
  endfunction

  function automatic logic wr_at(input logic wr, input logic [15:0] a, input logic [15:0] target);
    return wr && (a == target);
  endfunction

  wire  [STAT_W-1:0] stat_in;
  logic [7:0]        live_int;
  logic [7:0]        live_in;
  logic [7:0]        live_lh;
  logic [7:0]        live_cal;
  logic [7:0]        rd_val;

  // Raw monitor levels, all from outside the clock domain
  assign stat_in[POS_CAL]        = cal_progress;
  assign stat_in[POS_REF]        = ref_pin_loss;
  assign stat_in[POS_TMO]        = bus_timeout;
  assign stat_in[POS_LOSS +: NI] = signal_missing;
  assign stat_in[POS_FREQ +: NI] = freq_out_of_range;
  assign stat_in[POS_UNLK]       = loop_unlocked;
  assign stat_in[POS_HOLD]       = holdover;
  assign stat_in[POS_LCAL]       = loop_cal_busy;

  always_comb
  begin
    next_r = r;
    live_int = 8'h00;
    live_in  = 8'h00;
    live_lh  = 8'h00;
    live_cal = 8'h00;
    rd_val   = 8'h00;

    // Three-stage sampling; a change is taken once stages two and three agree
    next_r.sync1 = stat_in;
    next_r.sync2 = r.sync1;
    next_r.sync3 = r.sync2;
    for (int b = 0; b < STAT_W; b++)
    begin
      if (r.sync2[b] == r.sync3[b])
        next_r.filt[b] = r.sync3[b];
    end

    live_int[amrc_pkg::BIT_CAL_PROGRESS] = r.filt[POS_CAL];
    live_int[amrc_pkg::BIT_REF_PIN_LOSS] = r.filt[POS_REF] & ~r.ref_loss_off;
    live_int[amrc_pkg::BIT_BUS_TIMEOUT]  = r.filt[POS_TMO];
    live_in                              = {r.filt[POS_FREQ +: NI], r.alarm};
    live_lh[amrc_pkg::BIT_UNLOCK]        = r.filt[POS_UNLK];
    live_lh[amrc_pkg::BIT_HOLDOVER]      = r.filt[POS_HOLD];
    live_cal[amrc_pkg::BIT_LOOP_CAL]     = r.filt[POS_LCAL];

    // Loss qualification: alarm sets at once, clears after a clean run
    for (int n = 0; n < NI; n++)
    begin
      if (!r.loss_en[n])
      begin
        next_r.alarm[n] = 1'b0;
        next_r.cnt[n]   = '0;
      end
      else if (r.filt[POS_LOSS + n])
      begin
        next_r.alarm[n] = 1'b1;
        next_r.cnt[n]   = '0;
      end
      else if (r.alarm[n])
      begin
        if (r.cnt[n] >= val_limit(r.val_time[2*n +: 2]))
        begin
          next_r.alarm[n] = 1'b0;
          next_r.cnt[n]   = '0;
        end
        else
          next_r.cnt[n] = r.cnt[n] + CW'(1);
      end
    end

    next_r.sticky_int = sticky_next(r.sticky_int, live_int, wr_at(reg_wr, reg_addr, amrc_pkg::ADDR_STICKY_INT),
                                    reg_wdata, amrc_pkg::INT_BITS);
    next_r.sticky_in  = sticky_next(r.sticky_in, live_in, wr_at(reg_wr, reg_addr, amrc_pkg::ADDR_STICKY_IN),
                                    reg_wdata, 8'hff);
    next_r.sticky_lh  = sticky_next(r.sticky_lh, live_lh, wr_at(reg_wr, reg_addr, amrc_pkg::ADDR_STICKY_LH),
                                    reg_wdata, amrc_pkg::LH_BITS);
    next_r.sticky_cal = sticky_next(r.sticky_cal, live_cal, wr_at(reg_wr, reg_addr, amrc_pkg::ADDR_STICKY_CAL),
                                    reg_wdata, amrc_pkg::CAL_BITS);

    // Strobes read back as zero and last one cycle
    next_r.soft_all   = 1'b0;
    next_r.soft_outer = 1'b0;
    next_r.step_up    = 1'b0;
    next_r.step_down  = 1'b0;
    next_r.div_sync   = 1'b0;

    if (reg_wr)
    begin
      unique case (reg_addr)
        amrc_pkg::ADDR_MSK_INT:   next_r.msk_int = reg_wdata & amrc_pkg::MSK_INT_BITS;
        amrc_pkg::ADDR_MSK_IN:    next_r.msk_in  = reg_wdata;
        amrc_pkg::ADDR_MSK_LH:    next_r.msk_lh  = reg_wdata & amrc_pkg::LH_BITS;
        amrc_pkg::ADDR_MSK_CAL:   next_r.msk_cal = reg_wdata & amrc_pkg::CAL_BITS;
        amrc_pkg::ADDR_SOFT_RST:
        begin
          next_r.soft_all   = reg_wdata[amrc_pkg::BIT_SOFT_ALL];
          next_r.soft_outer = reg_wdata[amrc_pkg::BIT_SOFT_OUTER];
        end
        amrc_pkg::ADDR_FREQ_STEP:
        begin
          // Bit always reads 0, so every written 1 is a rising edge
          next_r.step_up   = reg_wdata[amrc_pkg::BIT_STEP_UP];
          next_r.step_down = reg_wdata[amrc_pkg::BIT_STEP_DOWN];
        end
        amrc_pkg::ADDR_POWER:
        begin
          next_r.low_power = reg_wdata[amrc_pkg::BIT_LOW_POWER];
          next_r.hard_rst  = reg_wdata[amrc_pkg::BIT_HARD_RST];
          next_r.div_sync  = reg_wdata[amrc_pkg::BIT_DIV_SYNC];
        end
        amrc_pkg::ADDR_WIRE_CFG:
        begin
          next_r.three_line   = reg_wdata[amrc_pkg::BIT_THREE_LINE];
          next_r.auto_refresh = reg_wdata[amrc_pkg::BIT_AUTO_REFRESH];
        end
        amrc_pkg::ADDR_LOSS_EN:
        begin
          next_r.loss_en      = reg_wdata[NI-1:0];
          next_r.ref_loss_off = reg_wdata[amrc_pkg::BIT_REF_LOSS_OFF];
        end
        amrc_pkg::ADDR_VAL_TIME:  next_r.val_time      = reg_wdata;
        amrc_pkg::ADDR_TRIG0_LO:  next_r.trig[0][7:0]  = reg_wdata;
        amrc_pkg::ADDR_TRIG0_HI:  next_r.trig[0][15:8] = reg_wdata;
        amrc_pkg::ADDR_TRIG1_LO:  next_r.trig[1][7:0]  = reg_wdata;
        amrc_pkg::ADDR_TRIG1_HI:  next_r.trig[1][15:8] = reg_wdata;
        amrc_pkg::ADDR_TRIG2_LO:  next_r.trig[2][7:0]  = reg_wdata;
        amrc_pkg::ADDR_TRIG2_HI:  next_r.trig[2][15:8] = reg_wdata;
        default:                  ;
      endcase
    end

    // Any unmasked sticky flag raises the line
    next_r.irq = |(r.sticky_int & ~r.msk_int & amrc_pkg::INT_BITS)
               | |(r.sticky_in  & ~r.msk_in)
               | |(r.sticky_lh  & ~r.msk_lh)
               | |(r.sticky_cal & ~r.msk_cal);

    // A read beside a write in one cycle sees the old value
    unique case (reg_addr)
      amrc_pkg::ADDR_LIVE_INT:   rd_val = live_int;
      amrc_pkg::ADDR_LIVE_IN:    rd_val = live_in;
      amrc_pkg::ADDR_LIVE_LH:    rd_val = live_lh;
      amrc_pkg::ADDR_LIVE_CAL:   rd_val = live_cal;
      amrc_pkg::ADDR_STICKY_INT: rd_val = r.sticky_int;
      amrc_pkg::ADDR_STICKY_IN:  rd_val = r.sticky_in;
      amrc_pkg::ADDR_STICKY_LH:  rd_val = r.sticky_lh;
      amrc_pkg::ADDR_STICKY_CAL: rd_val = r.sticky_cal;
      amrc_pkg::ADDR_MSK_INT:    rd_val = r.msk_int;
      amrc_pkg::ADDR_MSK_IN:     rd_val = r.msk_in;
      amrc_pkg::ADDR_MSK_LH:     rd_val = r.msk_lh;
      amrc_pkg::ADDR_MSK_CAL:    rd_val = r.msk_cal;
      amrc_pkg::ADDR_POWER:
      begin
        rd_val[amrc_pkg::BIT_LOW_POWER] = r.low_power;
        rd_val[amrc_pkg::BIT_HARD_RST]  = r.hard_rst;
      end
      amrc_pkg::ADDR_WIRE_CFG:
      begin
        rd_val[amrc_pkg::BIT_THREE_LINE]   = r.three_line;
        rd_val[amrc_pkg::BIT_AUTO_REFRESH] = r.auto_refresh;
      end
      amrc_pkg::ADDR_LOSS_EN:
      begin
        rd_val[NI-1:0]                     = r.loss_en;
        rd_val[amrc_pkg::BIT_REF_LOSS_OFF] = r.ref_loss_off;
      end
      amrc_pkg::ADDR_VAL_TIME:   rd_val = r.val_time;
      amrc_pkg::ADDR_TRIG0_LO:   rd_val = r.trig[0][7:0];
      amrc_pkg::ADDR_TRIG0_HI:   rd_val = r.trig[0][15:8];
      amrc_pkg::ADDR_TRIG1_LO:   rd_val = r.trig[1][7:0];
      amrc_pkg::ADDR_TRIG1_HI:   rd_val = r.trig[1][15:8];
      amrc_pkg::ADDR_TRIG2_LO:   rd_val = r.trig[2][7:0];
      amrc_pkg::ADDR_TRIG2_HI:   rd_val = r.trig[2][15:8];
      default:                   rd_val = 8'h00;
    endcase
    if (reg_rd)
      next_r.rdata = rd_val;

    // Hard reset clears everything but the serial wiring, the read data and the samplers;
    // it also clears its own bit, so it acts for exactly one cycle
    if (r.hard_rst)
    begin
      next_r            = reset_state();
      next_r.three_line = r.three_line;
      next_r.sync1      = r.sync1;
      next_r.sync2      = r.sync2;
      next_r.sync3      = r.sync3;
      next_r.filt       = r.filt;
      next_r.rdata      = r.rdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      r <= reset_state();
    else
      r <= next_r;
  end

  assign reg_rdata                 = r.rdata;
  assign irq_out                   = r.irq;
  assign soft_reset_all            = r.soft_all;
  assign outer_loop_init           = r.soft_outer;
  assign freq_step_up              = r.step_up;
  assign freq_step_down            = r.step_down;
  assign divider_sync              = r.div_sync;
  assign hard_reset                = r.hard_rst;
  assign low_power_request         = r.low_power;
  assign three_line_select         = r.three_line;
  assign auto_divider_refresh      = r.auto_refresh;
  assign input_loss_detect_on      = r.loss_en;
  assign ref_pin_loss_detect_off   = r.ref_loss_off;
  assign input_loss_trigger_level0 = r.trig[0];
  assign input_loss_trigger_level1 = r.trig[1];
  assign input_loss_trigger_level2 = r.trig[2];
  assign input_loss_alarm          = r.alarm;

endmodule

// [dv/amrc_alarm_ctrl_props.sv]
`timescale 1ns/1ps

module amrc_alarm_ctrl_props #(
  parameter int VAL_CYC0 = 4,
  parameter int VAL_CYC1 = 8,
  parameter int VAL_CYC2 = 12,
  parameter int VAL_CYC3 = 16
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Register port
  input wire logic        reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  // Watched outputs and loss input
  input wire logic        soft_reset_all,
  input wire logic        outer_loop_init,
  input wire logic        freq_step_up,
  input wire logic        freq_step_down,
  input wire logic        divider_sync,
  input wire logic        hard_reset,
  input wire logic        low_power_request,
  input wire logic [3:0]  input_loss_detect_on,
  input wire logic [15:0] input_loss_trigger_level0,
  input wire logic [3:0]  input_loss_alarm,
  input wire logic [3:0]  signal_missing
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Writes in the hard reset cycle are dropped, so they are not causes
  sequence wr_to(logic [15:0] a);
    reg_wr && !hard_reset && reg_addr == a;
  endsequence

  // Back-to-back strobe writes would legally stretch the pulse
  sequence lone_wr(logic [15:0] a, int b);
    wr_to(a) ##0 reg_wdata[b] ##1 !reg_wr;
  endsequence

  sequence one_pulse(logic s);
    s ##1 !s;
  endsequence

  a_step_up_pulse: assert property (lone_wr(16'h001d, 0) |-> one_pulse(freq_step_up))
    else $error("step up strobe wrong");
  a_step_down_pulse: assert property (lone_wr(16'h001d, 1) |-> one_pulse(freq_step_down))
    else $error("step down strobe wrong");
  a_soft_all_pulse: assert property (lone_wr(16'h001c, 0) |-> one_pulse(soft_reset_all))
    else $error("full soft reset strobe wrong");
  a_outer_init_pulse: assert property (lone_wr(16'h001c, 2) |-> one_pulse(outer_loop_init))
    else $error("outer loop strobe wrong");
  a_div_sync_pulse: assert property (lone_wr(16'h001e, 2) |-> one_pulse(divider_sync))
    else $error("divider sync strobe wrong");
  a_low_power_level: assert property (wr_to(16'h001e) |=> low_power_request == $past(reg_wdata[0]))
    else $error("low power level wrong");
  a_hard_rst_seq: assert property (wr_to(16'h001e) ##0 reg_wdata[1] |=>
    hard_reset ##1 (!hard_reset && !low_power_request && input_loss_detect_on == 4'h0))
    else $error("hard reset sequence wrong");
  a_trig_low_byte: assert property (wr_to(16'h002e) |=> input_loss_trigger_level0[7:0] == $past(reg_wdata))
    else $error("trigger low byte wrong");
  // Four filter edges plus the shortest qualify time keep a loss in view
  a_alarm_no_early: assert property ($fell(input_loss_alarm[1]) && input_loss_detect_on[1] |->
    !$past(signal_missing[1], 8))
    else $error("loss alarm dropped early");
  a_hold_no_step: assert property (hard_reset |=> !freq_step_up && !freq_step_down &&
    input_loss_trigger_level0 == 16'h0000)
    else $error("hard reset left state behind");
endmodule

bind amrc_alarm_ctrl amrc_alarm_ctrl_props #(
  .VAL_CYC0(VAL_CYC0),
  .VAL_CYC1(VAL_CYC1),
  .VAL_CYC2(VAL_CYC2),
  .VAL_CYC3(VAL_CYC3)
) props_u (
  .mclk(mclk),
  .rst(rst),
  .reg_wr(reg_wr),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .soft_reset_all(soft_reset_all),
  .outer_loop_init(outer_loop_init),
  .freq_step_up(freq_step_up),
  .freq_step_down(freq_step_down),
  .divider_sync(divider_sync),
  .hard_reset(hard_reset),
  .low_power_request(low_power_request),
  .input_loss_detect_on(input_loss_detect_on),
  .input_loss_trigger_level0(input_loss_trigger_level0),
  .input_loss_alarm(input_loss_alarm),
  .signal_missing(signal_missing)
);

// [dv/amrc_host_model.sv]
`timescale 1ns/1ps

module amrc_host_model (
  // Register port
  input  wire logic        mclk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_addr,
  output logic      [7:0]  reg_wdata,
  input  wire logic [7:0]  reg_rdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
  end

  // Idle lines show the inverse so a stale value is never mistaken for a request
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = (a == amrc_pkg::ADDR_MSK_INT) ? (d | 8'hc0) : d;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

// [dv/alarm_mask_and_reset_control_test.sv]
`timescale 1ns/1ps

module alarm_mask_and_reset_control_test;
  logic        mclk;
  logic        rst;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [31:0] src;
  wire  [4:0]  strb;
  wire  [2:0]  ctl;
  wire  [4:0]  det;
  wire  [47:0] lvl;
  logic [3:0]  alarm;
  logic        irq_out;
  logic        hard_reset;
  int          bad_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          n;
  int          vt [4] = '{4, 12, 20, 28};
  logic [31:0] impl = {amrc_pkg::CAL_BITS, amrc_pkg::LH_BITS, 8'hff, amrc_pkg::INT_BITS};
  logic [15:0] sa [5] = '{16'h001c, 16'h001c, 16'h001d, 16'h001d, 16'h001e};
  logic [7:0]  sd [5] = '{8'h01, 8'h04, 8'h01, 8'h02, 8'h04};

  amrc_host_model hm (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  amrc_alarm_ctrl #(.VAL_CYC0(4), .VAL_CYC1(12), .VAL_CYC2(20), .VAL_CYC3(28)) dut_u (
    .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cal_progress(src[0]), .ref_pin_loss(src[1]),
    .bus_timeout(src[5]), .signal_missing(src[11:8]), .freq_out_of_range(src[15:12]),
    .loop_unlocked(src[17]), .holdover(src[21]), .loop_cal_busy(src[29]), .irq_out(irq_out),
    .soft_reset_all(strb[4]), .outer_loop_init(strb[3]), .freq_step_up(strb[2]),
    .freq_step_down(strb[1]), .divider_sync(strb[0]), .hard_reset(hard_reset),
    .low_power_request(ctl[2]), .three_line_select(ctl[1]), .auto_divider_refresh(ctl[0]),
    .input_loss_detect_on(det[3:0]), .ref_pin_loss_detect_off(det[4]),
    .input_loss_trigger_level0(lvl[15:0]), .input_loss_trigger_level1(lvl[31:16]),
    .input_loss_trigger_level2(lvl[47:32]), .input_loss_alarm(alarm));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    hm.rd(a, d);
    chk(64'(d), 64'(e));
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Whole run needs about 660 cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  initial
  begin
    rst = 1'b1;
    src = '0;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    chk_rd(amrc_pkg::ADDR_MSK_INT, 8'hc0);
    chk_rd(amrc_pkg::ADDR_MSK_IN, 8'h00);
    chk({strb, ctl, hard_reset, irq_out, det, lvl}, 64'h0);
    $display("test reset done");
    hm.wr(amrc_pkg::ADDR_LOSS_EN, 8'h0f);
    for (int b = 0; b < 32; b++)
    begin
      if (impl[b])
      begin
        src[b] = 1'b1;
        cyc(8);
        chk_rd(amrc_pkg::ADDR_STICKY_INT + 16'(b / 8), 8'h01 << (b % 8));
        chk(irq_out, 1);
        hm.wr(amrc_pkg::ADDR_MSK_INT + 16'(b / 8), 8'h01 << (b % 8));
        cyc(2);
        chk(irq_out, 0);
        src[b] = 1'b0;
        cyc(12);
        hm.wr(amrc_pkg::ADDR_STICKY_INT + 16'(b / 8), 8'h00);
        hm.wr(amrc_pkg::ADDR_MSK_INT + 16'(b / 8), 8'h00);
        cyc(2);
        chk(irq_out, 0);
        chk_rd(amrc_pkg::ADDR_STICKY_INT + 16'(b / 8), 8'h00);
      end
    end
    $display("test masks done");
    for (int i = 0; i < 5; i++)
    begin
      hm.wr(sa[i], sd[i]);
      chk(strb, 5'h10 >> i);
      cyc(1);
      chk(strb, 0);
      chk_rd(sa[i], 8'h00);
    end
    hm.wr(amrc_pkg::ADDR_SOFT_RST, 8'h00);
    chk(strb, 0);
    $display("test strobes done");
    hm.wr(amrc_pkg::ADDR_LOSS_EN, 8'h02);
    for (int c = 0; c < 4; c++)
    begin
      hm.wr(amrc_pkg::ADDR_VAL_TIME, 8'(c << 2));
      src[9:8] = 2'b11;
      cyc(6);
      chk(alarm[1:0], 2'b10);
      src[9:8] = 2'b00;
      n = 0;
      while (alarm[1] === 1'b1 && n < 100)
      begin
        cyc(1);
        n++;
      end
      chk(n >= vt[c] + 3 && n <= vt[c] + 5, 1);
    end
    $display("test qualify done");
    hm.wr(amrc_pkg::ADDR_POWER, 8'h01);
    chk(ctl[2], 1);
    chk_rd(amrc_pkg::ADDR_POWER, 8'h01);
    hm.wr(amrc_pkg::ADDR_WIRE_CFG, 8'h28);
    chk(ctl[1:0], 2'b11);
    hm.wr(amrc_pkg::ADDR_LOSS_EN, 8'h15);
    chk(det, 5'h15);
    src[1] = 1'b1;
    cyc(8);
    chk_rd(amrc_pkg::ADDR_STICKY_INT, 8'h00);
    src[1] = 1'b0;
    hm.wr(amrc_pkg::ADDR_MSK_IN, 8'hff);
    for (int k = 0; k < 6; k++)
      hm.wr(amrc_pkg::ADDR_TRIG0_LO + 16'(k), 8'(8'h11 * (k + 1)));
    chk(lvl, 48'h665544332211);
    hm.wr(amrc_pkg::ADDR_POWER, 8'h03);
    chk(hard_reset, 1);
    cyc(1);
    chk({hard_reset, ctl[2:1], det, lvl}, {3'b001, 53'h0});
    chk_rd(amrc_pkg::ADDR_MSK_IN, 8'h00);
    chk_rd(amrc_pkg::ADDR_MSK_INT, 8'hc0);
    $display("test controls done");
    give_verdict();
  end
endmodule
